/* design/gpio_consts.svh */
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// Register byte offsets
`define OFF_PIN_LEVEL      12'h000
`define OFF_OUTPUT_LATCH   12'h004
`define OFF_DIRECTION      12'h008
`define OFF_ANALOG_SELECT  12'h00c
`define OFF_PULLUP         12'h010
`define OFF_THRESHOLD      12'h014
`define OFF_SLEW_LIMIT     12'h018
`define OFF_OPEN_DRAIN     12'h01c
`define OFF_PERIPH_ENABLE  12'h020
`define OFF_ANALOG_OUT     12'h024
`define OFF_SERIAL_OWN     12'h028

// Reset values (6-bit port)
`define RST_DIRECTION      6'h3f
`define RST_ANALOG_SELECT  6'h3f
`define RST_PULLUP         6'h00
`define RST_THRESHOLD      6'h3f
`define RST_SLEW_LIMIT     6'h3f
`define RST_OPEN_DRAIN     6'h00
`define RST_OUTPUT_LATCH   6'h00
`define RST_PERIPH         6'h00

// AHB transfer type and response
`define HTRANS_NONSEQ      2'h2
`define HRESP_OKAY         1'b0

`endif

/* design/gpio_pkg.sv */
package gpio_pkg;
    typedef enum logic [3:0] {
        REG_PIN_LEVEL,
        REG_OUTPUT_LATCH,
        REG_DIRECTION,
        REG_ANALOG_SELECT,
        REG_PULLUP,
        REG_THRESHOLD,
        REG_SLEW_LIMIT,
        REG_OPEN_DRAIN,
        REG_PERIPH_ENABLE,
        REG_ANALOG_OUT,
        REG_SERIAL_OWN,
        REG_NONE
    } reg_sel_t;
endpackage

/* design/general_purpose_io_port.sv */
`timescale 1ns/1ps
`include "gpio_consts.svh"
// How it works
// - Pin read gives pins, latch read gives latch
// - Either register write updates the latch
// - Writes replace the whole latch with the written word
// - First port has six bidirectional pins
// - Direction one disables the output driver
// - Direction zero drives latch onto pin
// - Direction controls drivers even in analog mode
// - Analog select disables digital input buffer
// - Digital reads of analog pins return zero
// - Analog select does not block digital output
// - Analog select resets to analog mode
// - Output defaults to latch after reset
// - Enabled peripheral blocks latch drive, readable
// - Analog output overrides all digital drivers
// - Analog inputs connect whenever analog selected
// - Open-drain drives low or releases only
// - Serial bus ownership forces open-drain
// - Slew bit set limits slew rate
// - Threshold choice feeds reads
// - Separate weak pull-up enable per pin
// - Threshold one Schmitt, zero TTL
// - Pull-up disabled while pad driver is enabled
module general_purpose_io_port #(
    parameter int WIDTH = 6
) (
    input  wire logic             hclk,              // System clock
    input  wire logic             hresetn,           // Async reset, low
    input  wire logic             hsel,              // Slave select
    input  wire logic [11:0]      haddr,             // Byte address
    input  wire logic [1:0]       htrans,            // Transfer type
    input  wire logic             hwrite,            // Write
    input  wire logic [2:0]       hsize,             // Size, word only
    input  wire logic             hready,            // Bus ready in
    input  wire logic [31:0]      hwdata,            // Write data
    output logic      [31:0]      hrdata,            // Read data
    output logic                  hreadyout,         // Slave ready
    output logic                  hresp,             // Response
    input  wire logic [WIDTH-1:0] pin_in,            // Pad level
    input  wire logic [WIDTH-1:0] periph_out,        // Peripheral drive value
    input  wire logic [WIDTH-1:0] periph_oe,         // Peripheral wants drive
    output logic      [WIDTH-1:0] pin_out,           // Pad drive value
    output logic      [WIDTH-1:0] pin_oe,            // Pad driver enable
    output logic      [WIDTH-1:0] pullup_on,         // Weak pull-up active
    output logic      [WIDTH-1:0] slew_limited,      // Limited slew control
    output logic      [WIDTH-1:0] schmitt_select,    // Schmitt threshold on
    output logic      [WIDTH-1:0] analog_connect,    // Analog input switch
    output logic      [WIDTH-1:0] digital_in_enable, // Digital buffer enable
    output logic      [WIDTH-1:0] digital_in         // Synced pin value
);
    // ==========================================================
    // Registers
    // ==========================================================
    logic [WIDTH-1:0] output_latch_reg;
    logic [WIDTH-1:0] direction_bits;
    logic [WIDTH-1:0] analog_select_bits;
    logic [WIDTH-1:0] pullup_enable_bits;
    logic [WIDTH-1:0] input_threshold_bits;
    logic [WIDTH-1:0] slew_limit_bits;
    logic [WIDTH-1:0] open_drain_bits;
    logic [WIDTH-1:0] periph_enable_bits;
    logic [WIDTH-1:0] analog_out_bits;
    logic [WIDTH-1:0] serial_own_bits;
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] pin_level_reg;
    logic             wr_pend;
    gpio_pkg::reg_sel_t wr_sel;
    gpio_pkg::reg_sel_t addr_sel;
    logic             take;

    function automatic gpio_pkg::reg_sel_t decode(input logic [11:0] a);
        unique case (a)
            `OFF_PIN_LEVEL:     decode = gpio_pkg::REG_PIN_LEVEL;
            `OFF_OUTPUT_LATCH:  decode = gpio_pkg::REG_OUTPUT_LATCH;
            `OFF_DIRECTION:     decode = gpio_pkg::REG_DIRECTION;
            `OFF_ANALOG_SELECT: decode = gpio_pkg::REG_ANALOG_SELECT;
            `OFF_PULLUP:        decode = gpio_pkg::REG_PULLUP;
            `OFF_THRESHOLD:     decode = gpio_pkg::REG_THRESHOLD;
            `OFF_SLEW_LIMIT:    decode = gpio_pkg::REG_SLEW_LIMIT;
            `OFF_OPEN_DRAIN:    decode = gpio_pkg::REG_OPEN_DRAIN;
            `OFF_PERIPH_ENABLE: decode = gpio_pkg::REG_PERIPH_ENABLE;
            `OFF_ANALOG_OUT:    decode = gpio_pkg::REG_ANALOG_OUT;
            `OFF_SERIAL_OWN:    decode = gpio_pkg::REG_SERIAL_OWN;
            default:            decode = gpio_pkg::REG_NONE;
        endcase
    endfunction

    // ==========================================================
    // Input path
    // ==========================================================
    // Pad sampled asynchronously to hclk, so two stages first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
        end
    end

    // Threshold choice is electrical; the chosen buffer feeds reads
    assign schmitt_select    = input_threshold_bits;
    assign digital_in_enable = ~analog_select_bits;
    assign analog_connect    = analog_select_bits;
    assign pin_level_reg     = sync2 & ~analog_select_bits;
    assign digital_in        = pin_level_reg;

    // ==========================================================
    // Output path
    // ==========================================================
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            logic drv_val;
            logic drv_en;
            logic od;
            drv_val = output_latch_reg[i];
            drv_en  = ~direction_bits[i];
            if (periph_enable_bits[i]) begin
                drv_val = periph_out[i];
                drv_en  = periph_oe[i];
            end
            od = open_drain_bits[i] | serial_own_bits[i];
            pin_out[i] = od ? 1'b0 : drv_val;
            pin_oe[i]  = drv_en & ~(od & drv_val)
                         & ~analog_out_bits[i];
        end
    end

    assign pullup_on    = pullup_enable_bits & ~pin_oe;
    assign slew_limited = slew_limit_bits;

    // ==========================================================
    // AHB-Lite slave, zero wait states
    // ==========================================================
    assign take      = hsel & hready & htrans[1];
    assign addr_sel  = decode(haddr);
    assign hreadyout = 1'b1;
    assign hresp     = `HRESP_OKAY;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_sel  <= gpio_pkg::REG_NONE;
        end else begin
            wr_pend <= take & hwrite;
            wr_sel  <= addr_sel;
        end
    end

    // Read data registered from address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= 32'h0000_0000;
            unique case (addr_sel)
                gpio_pkg::REG_PIN_LEVEL:     hrdata[WIDTH-1:0] <= pin_level_reg;
                gpio_pkg::REG_OUTPUT_LATCH:  hrdata[WIDTH-1:0] <= output_latch_reg;
                gpio_pkg::REG_DIRECTION:     hrdata[WIDTH-1:0] <= direction_bits;
                gpio_pkg::REG_ANALOG_SELECT: hrdata[WIDTH-1:0] <= analog_select_bits;
                gpio_pkg::REG_PULLUP:        hrdata[WIDTH-1:0] <= pullup_enable_bits;
                gpio_pkg::REG_THRESHOLD:     hrdata[WIDTH-1:0] <= input_threshold_bits;
                gpio_pkg::REG_SLEW_LIMIT:    hrdata[WIDTH-1:0] <= slew_limit_bits;
                gpio_pkg::REG_OPEN_DRAIN:    hrdata[WIDTH-1:0] <= open_drain_bits;
                gpio_pkg::REG_PERIPH_ENABLE: hrdata[WIDTH-1:0] <= periph_enable_bits;
                gpio_pkg::REG_ANALOG_OUT:    hrdata[WIDTH-1:0] <= analog_out_bits;
                gpio_pkg::REG_SERIAL_OWN:    hrdata[WIDTH-1:0] <= serial_own_bits;
                gpio_pkg::REG_NONE:          hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Latch: whole word replaces latch, so the merge is the written value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            output_latch_reg <= `RST_OUTPUT_LATCH;
        end else if (wr_pend && (wr_sel == gpio_pkg::REG_PIN_LEVEL
                              || wr_sel == gpio_pkg::REG_OUTPUT_LATCH)) begin
            output_latch_reg <= hwdata[WIDTH-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            direction_bits       <= `RST_DIRECTION;
            analog_select_bits   <= `RST_ANALOG_SELECT;
            pullup_enable_bits   <= `RST_PULLUP;
            input_threshold_bits <= `RST_THRESHOLD;
            slew_limit_bits      <= `RST_SLEW_LIMIT;
            open_drain_bits      <= `RST_OPEN_DRAIN;
            periph_enable_bits   <= `RST_PERIPH;
            analog_out_bits      <= `RST_PERIPH;
            serial_own_bits      <= `RST_PERIPH;
        end else if (wr_pend) begin
            unique case (wr_sel)
                gpio_pkg::REG_DIRECTION:     direction_bits       <= hwdata[WIDTH-1:0];
                gpio_pkg::REG_ANALOG_SELECT: analog_select_bits   <= hwdata[WIDTH-1:0];
                gpio_pkg::REG_PULLUP:        pullup_enable_bits   <= hwdata[WIDTH-1:0];
                gpio_pkg::REG_THRESHOLD:     input_threshold_bits <= hwdata[WIDTH-1:0];
                gpio_pkg::REG_SLEW_LIMIT:    slew_limit_bits      <= hwdata[WIDTH-1:0];
                gpio_pkg::REG_OPEN_DRAIN:    open_drain_bits      <= hwdata[WIDTH-1:0];
                gpio_pkg::REG_PERIPH_ENABLE: periph_enable_bits   <= hwdata[WIDTH-1:0];
                gpio_pkg::REG_ANALOG_OUT:    analog_out_bits      <= hwdata[WIDTH-1:0];
                gpio_pkg::REG_SERIAL_OWN:    serial_own_bits      <= hwdata[WIDTH-1:0];
                default: ;
            endcase
        end
    end
endmodule

/* test/gpio_pad_model.sv */
`timescale 1ns/1ps
// ==========
// Pads: outside drivers, pull-ups, floating lines
module gpio_pad_model #(
    parameter int WIDTH = 6
) (
    input  logic             hclk,      // Clock
    input  logic [WIDTH-1:0] pin_out,   // Pad value
    input  logic [WIDTH-1:0] pin_oe,    // Pad enable
    input  logic [WIDTH-1:0] pullup_on, // Pull-up
    input  logic [WIDTH-1:0] ext_en,    // Outside drive
    input  logic [WIDTH-1:0] ext_val,   // Outside value
    output logic [WIDTH-1:0] pin_in     // Pad level
);
    logic [WIDTH-1:0] flt = '0;
    // Floating lines wander so a stale level never reads as valid
    always @(posedge hclk) flt <= ~flt;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                  | (~pin_oe & ~ext_en & (pullup_on | flt));
endmodule

/* test/general_purpose_io_port_assertions.sv */
`timescale 1ns/1ps
`include "gpio_consts.svh"
// ==========
// Port checker
module gpio_port_checker #(
    parameter int WIDTH = 6
) (
    input logic             hclk,              // Clock
    input logic             hresetn,           // Reset
    input logic             hsel,              // Select
    input logic [11:0]      haddr,             // Address
    input logic [1:0]       htrans,            // Transfer
    input logic             hwrite,            // Write
    input logic             hready,            // Ready
    input logic [31:0]      hwdata,            // Data
    input logic [WIDTH-1:0] pin_in,            // Pad level
    input logic [WIDTH-1:0] periph_out,        // Periph value
    input logic [WIDTH-1:0] periph_oe,         // Periph enable
    input logic [WIDTH-1:0] pin_out,           // Pad value
    input logic [WIDTH-1:0] pin_oe,            // Pad enable
    input logic [WIDTH-1:0] pullup_on,         // Pull-up
    input logic [WIDTH-1:0] slew_limited,      // Slew
    input logic [WIDTH-1:0] schmitt_select,    // Threshold
    input logic [WIDTH-1:0] analog_connect,    // Analog
    input logic [WIDTH-1:0] digital_in_enable, // Buffer
    input logic [WIDTH-1:0] digital_in         // Synced
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic take;
    assign take = hsel && hready && htrans[1] && hwrite;
    a_analog_reads_zero: assert property ((digital_in & analog_connect) == '0)
        else $error("analog pin reads nonzero");
    a_buffer_off: assert property (digital_in_enable == ~analog_connect)
        else $error("digital buffer not off");
    a_pullup_output_off: assert property ((pullup_on & pin_oe) == '0)
        else $error("pull-up on driven pin");
    a_periph_drives: assert property ((pin_oe & periph_oe & (pin_out ^ periph_out)) == '0)
        else $error("peripheral value not on pin");
    a_sync_two_flop: assert property ($past(hresetn) && $past(hresetn, 2)
        && analog_connect == $past(analog_connect) && analog_connect == $past(analog_connect, 2)
        |-> digital_in == ($past(pin_in, 2) & ~analog_connect)) else $error("sync delay wrong");
    a_reset_state: assert property ($rose(hresetn) |-> analog_connect == '1
        && pin_oe == '0 && slew_limited == '1) else $error("reset state wrong");
    a_slew_write: assert property (take && haddr == `OFF_SLEW_LIMIT
        |-> ##2 slew_limited == $past(hwdata[WIDTH-1:0])) else $error("slew not written");
    a_threshold_write: assert property (take && haddr == `OFF_THRESHOLD
        |-> ##2 schmitt_select == $past(hwdata[WIDTH-1:0])) else $error("threshold not written");
endmodule
bind general_purpose_io_port gpio_port_checker #(.WIDTH(WIDTH)) chk (.*);

/* test/tb_general_purpose_io_port.sv */
`timescale 1ns/1ps
`include "gpio_consts.svh"
// ==========
// Bench
module tb_general_purpose_io_port;
    typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_t;
    logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready;
    logic [11:0] haddr = 12'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic        hreadyout, hresp;
    logic [5:0]  periph_out = 6'h0, periph_oe = 6'h0, ext_en = 6'h0, ext_val = 6'h0;
    logic [5:0]  pin_in, pin_out, pin_oe, pullup_on, slew_limited, schmitt_select;
    logic [5:0]  analog_connect, digital_in_enable, digital_in;
    int          num_errors = 0;
    int          checked = 0;
    row_t rows[8] = '{
        '{`OFF_ANALOG_SELECT, 32'h0, 32'h0},
        '{`OFF_DIRECTION, 32'h38, 32'h38},
        '{`OFF_PULLUP, 32'h3f, 32'h3f},
        '{`OFF_THRESHOLD, 32'hffffff15, 32'h15},
        '{`OFF_SLEW_LIMIT, 32'h2a, 32'h2a},
        '{`OFF_OPEN_DRAIN, 32'h0, 32'h0},
        '{`OFF_OUTPUT_LATCH, 32'h5, 32'h5},
        '{12'h030, 32'hff, 32'h0}};
    row_t rst[7] = '{'{`OFF_DIRECTION, 32'h0, 32'h3f}, '{`OFF_ANALOG_SELECT, 32'h0, 32'h3f},
        '{`OFF_PULLUP, 32'h0, 32'h0}, '{`OFF_THRESHOLD, 32'h0, 32'h3f},
        '{`OFF_SLEW_LIMIT, 32'h0, 32'h3f}, '{`OFF_OPEN_DRAIN, 32'h0, 32'h0},
        '{`OFF_OUTPUT_LATCH, 32'h0, 32'h0}};
    assign hready = hreadyout;
    general_purpose_io_port dut (.*);
    gpio_pad_model pads (.*);
    initial begin
        forever #25 hclk = ~hclk;
    end
    task automatic give_verdict();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // Bounded wait: a stuck ready ends the run instead of hanging
    task automatic edge_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'h1) begin
            n++;
            if (n > 50) begin
                num_errors++;
                give_verdict();
            end
            @(posedge hclk);
        end
    endtask
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= `HTRANS_NONSEQ;
        edge_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        edge_rdy();
        rd = hrdata;
    endtask
    // ==========
    // Main sequence
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        ext_en <= 6'h38;
        ext_val <= 6'h28;
        foreach (rows[i]) begin
            xfer(rows[i].a, 1'h1, rows[i].d);
            xfer(rows[i].a, 1'h0, 32'h0);
            chk("register", rows[i].e, rd);
        end
        @(negedge hclk);
        chk("pin_oe", 32'h07, 32'(pin_oe));
        chk("pin_out", 32'h05, 32'(pin_out & pin_oe));
        chk("pullup_on", 32'h38, 32'(pullup_on));
        chk("slew_limited", 32'h2a, 32'(slew_limited));
        chk("schmitt_select", 32'h15, 32'(schmitt_select));
        chk("digital_in", 32'h2d, 32'(digital_in));
        xfer(`OFF_PIN_LEVEL, 1'h0, 32'h0);
        chk("pin level", 32'h2d, rd);
        xfer(`OFF_PIN_LEVEL, 1'h1, 32'h02);
        xfer(`OFF_OUTPUT_LATCH, 1'h0, 32'h0);
        chk("latch", 32'h02, rd);
        $display("table done");
        xfer(`OFF_ANALOG_SELECT, 1'h1, 32'h09);
        repeat (3) @(posedge hclk);
        xfer(`OFF_PIN_LEVEL, 1'h0, 32'h0);
        chk("analog read", 32'h22, rd);
        chk("analog drive", 32'h07, 32'(pin_oe));
        chk("analog_connect", 32'h09, 32'(analog_connect));
        chk("digital_in_enable", 32'h36, 32'(digital_in_enable));
        chk("hresp", 32'h0, 32'(hresp));
        xfer(`OFF_OPEN_DRAIN, 1'h1, 32'h07);
        @(negedge hclk);
        chk("od pin_oe", 32'h05, 32'(pin_oe));
        chk("od pin_out", 32'h00, 32'(pin_out & pin_oe));
        chk("od pullup_on", 32'h3a, 32'(pullup_on));
        xfer(`OFF_OPEN_DRAIN, 1'h1, 32'h00);
        xfer(`OFF_SERIAL_OWN, 1'h1, 32'h02);
        @(negedge hclk);
        chk("serial pin_oe", 32'h05, 32'(pin_oe));
        xfer(`OFF_SERIAL_OWN, 1'h1, 32'h00);
        periph_oe <= 6'h30;
        periph_out <= 6'h10;
        xfer(`OFF_PERIPH_ENABLE, 1'h1, 32'h30);
        @(negedge hclk);
        chk("periph pin_oe", 32'h37, 32'(pin_oe));
        chk("periph pin_out", 32'h12, 32'(pin_out & pin_oe));
        xfer(`OFF_ANALOG_OUT, 1'h1, 32'h31);
        @(negedge hclk);
        chk("aout pin_oe", 32'h06, 32'(pin_oe));
        $display("pin tests done");
        @(posedge hclk);
        hresetn <= 1'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        @(negedge hclk);
        chk("reset pin_oe", 32'h00, 32'(pin_oe));
        foreach (rst[i]) begin
            xfer(rst[i].a, 1'h0, 32'h0);
            chk("reset value", rst[i].e, rd);
        end
        xfer(`OFF_OUTPUT_LATCH, 1'h1, 32'h2a);
        xfer(`OFF_DIRECTION, 1'h1, 32'h00);
        @(negedge hclk);
        chk("latch drive", 32'h2a, 32'(pin_out & pin_oe));
        $display("reset tests done");
        give_verdict();
    end
endmodule
